/* include/reset_exc_consts.svh */
// register offsets, field positions, reset values and osc counts of the exception unit
`ifndef RESET_EXC_CONSTS_SVH
`define RESET_EXC_CONSTS_SVH
`define OFS_PEND_HIGH 12'h000
`define OFS_PEND_MID 12'h004
`define OFS_PEND_LOW 12'h008
`define OFS_CAUSE 12'h00C
`define OFS_CTRL 12'h010
`define CAUSE_ILLEGAL_BIT 0
`define CAUSE_BADFETCH_BIT 1
`define CAUSE_UNDERVOLT_BIT 2
`define CAUSE_MONITOR_BIT 3
`define CAUSE_PIN_BIT 4
`define CTRL_STOP_EN_BIT 0
`define CTRL_SHORT_REC_BIT 1
`define CTRL_RESET 2'h0
`define CNT_WIDTH 13
`define LONG_OSC_CYCLES 4096
`define PIN_LOW_OSC_CYCLES 32
`define HOLD_OSC_CYCLES 32
`define LONG_HOLD_OSC_CYCLES 64
`define SHORT_REC_OSC_CYCLES 32
`define VEC_SWI 5'h01
`define VEC_SRC_BASE 5'h02
`endif

/* include/reset_exc_pkg.sv */
// types shared by the reset and exception unit
package reset_exc_pkg;
  typedef enum logic [2:0] {
    ST_RUN = 3'b000,
    ST_PIN = 3'b001,
    ST_HOLD = 3'b010,
    ST_EXT = 3'b011,
    ST_STOP = 3'b100,
    ST_RECOVER = 3'b101
  } seq_state_t;
  typedef logic [4:0] vector_code_t;
  typedef logic [15:0] source_vec_t;
endpackage : reset_exc_pkg

/* rtl/reset_and_exception_control.sv */
// reset sequencing, system counter and interrupt arbitration of the exception unit
`timescale 1ns/1ps
`default_nettype none
`include "reset_exc_consts.svh"

module reset_and_exception_control #(
  parameter int LONG_COUNT = `LONG_OSC_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic osc_clk,
  input wire logic undefined_insn,
  input wire logic stop_insn,
  input wire logic opcode_fetch,
  input wire logic unmapped_access,
  input wire logic undervoltage,
  input wire logic monitor_entry_reset,
  input wire logic rst_pin_i,
  output logic rst_pin_o,
  output logic rst_pin_oe,
  output logic internal_reset_line,
  output logic bus_clk_en,
  output logic watchdog_tick,
  input wire logic insn_done,
  input wire logic interrupt_mask_bit,
  input wire reset_exc_pkg::source_vec_t irq_req,
  input wire reset_exc_pkg::source_vec_t irq_en,
  input wire logic swi_insn,
  input wire logic rti_insn,
  input wire logic break_req,
  input wire logic vector_ack,
  output logic int_entry,
  output reset_exc_pkg::vector_code_t vector_sel,
  output logic stack_pc_minus_one,
  output logic push_index_high,
  output logic restore_regs
);
  import reset_exc_pkg::*;

  localparam logic [12:0] LONG_LAST = 13'(LONG_COUNT - 1);
  localparam logic [12:0] PIN_LAST = 13'(`PIN_LOW_OSC_CYCLES - 1);
  localparam logic [12:0] HOLD_LAST = 13'(`HOLD_OSC_CYCLES - 1);
  localparam logic [12:0] LHOLD_LAST = 13'(`LONG_HOLD_OSC_CYCLES - 1);
  localparam logic [12:0] SREC_LAST = 13'(`SHORT_REC_OSC_CYCLES - 1);

  // highest priority is the lowest source index
  function automatic vector_code_t pick_source(input source_vec_t req);
    vector_code_t code;
    code = `VEC_SRC_BASE;
    for (int i = 15; i >= 0; i--) begin
      if (req[i]) begin
        code = 5'(`VEC_SRC_BASE + i);
      end
    end
    return code;
  endfunction : pick_source

  seq_state_t state_q, state_d;
  logic [`CNT_WIDTH-1:0] cnt_q, cnt_d;
  logic long_q, long_d;
  logic osc_q;
  logic [1:0] ctrl_q;
  logic [4:0] cause_q;
  logic lat_q;
  vector_code_t vec_q;
  logic pcm1_q, entry_q, restore_q, wd_q;
  logic oe_q, internal_reset_line_q, busen_q;
  logic [31:0] rdata_q;
  logic ready_q, err_q;

  // oscillator falling edge as a one-cycle enable
  wire osc_tick = osc_q & ~osc_clk;
  wire stop_en = ctrl_q[`CTRL_STOP_EN_BIT];
  wire short_rec = ctrl_q[`CTRL_SHORT_REC_BIT];

  wire ev_illegal = undefined_insn | (stop_insn & ~stop_en);
  // only opcode fetches count; data accesses are ignored here
  wire ev_badfetch = unmapped_access & opcode_fetch;
  wire ev_undervolt = undervoltage;
  wire ev_monitor = monitor_entry_reset;
  wire ev_internal = ev_illegal | ev_badfetch | ev_undervolt | ev_monitor;
  wire ext_low = ~rst_pin_i & ~oe_q;
  wire stop_go = stop_insn & stop_en & (state_q == ST_RUN) & ~ev_internal;

  wire cnt_wrap = osc_tick & (cnt_q == {`CNT_WIDTH{1'b1}});
  wire pin_done = osc_tick & (cnt_q == (long_q ? LONG_LAST : PIN_LAST));
  wire hold_done = osc_tick & (cnt_q == (long_q ? LHOLD_LAST : HOLD_LAST));
  wire rec_done = osc_tick & (cnt_q == (short_rec ? SREC_LAST : LONG_LAST));
  wire wake = (|(irq_req & irq_en)) | break_req;

  always_comb begin
    state_d = state_q;
    long_d = long_q;
    // external reset never touches the count
    cnt_d = osc_tick ? cnt_q + 13'h0001 : cnt_q;
    if (ev_internal) begin
      state_d = ST_PIN;
      long_d = ev_undervolt;
      cnt_d = '0;
    end else begin
      unique case (state_q)
        ST_RUN: begin
          if (ext_low) begin
            state_d = ST_EXT;
          end else if (stop_go) begin
            state_d = ST_STOP;
            cnt_d = '0;
          end
        end
        ST_PIN: begin
          if (pin_done) begin
            state_d = ST_HOLD;
            cnt_d = '0;
          end
        end
        ST_HOLD: begin
          if (hold_done) begin
            state_d = ST_RUN;
          end
        end
        ST_EXT: begin
          if (rst_pin_i) begin
            state_d = ST_RUN;
          end
        end
        ST_STOP: begin
          cnt_d = '0;
          if (wake | ext_low) begin
            state_d = ST_RECOVER;
          end
        end
        ST_RECOVER: begin
          if (rec_done) begin
            state_d = ext_low ? ST_EXT : ST_RUN;
          end
        end
        default: begin
          state_d = ST_PIN;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= ST_PIN;
      long_q <= 1'b1;
      cnt_q <= '0;
      osc_q <= 1'b0;
    end else begin
      state_q <= state_d;
      long_q <= long_d;
      cnt_q <= cnt_d;
      osc_q <= osc_clk;
    end
  end

  // pin and line levels follow the next state so they land with it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      oe_q <= 1'b1;
      internal_reset_line_q <= 1'b1;
      busen_q <= 1'b0;
      wd_q <= 1'b0;
    end else begin
      oe_q <= (state_d == ST_PIN);
      internal_reset_line_q <= (state_d == ST_PIN) | (state_d == ST_HOLD) | (state_d == ST_EXT);
      busen_q <= (state_d == ST_RUN) | (state_d == ST_EXT);
      wd_q <= cnt_wrap;
    end
  end

  // interrupt latch and arbitration, only while running at instruction end
  wire run_ok = (state_q == ST_RUN) & ~ev_internal & ~ext_low;
  wire at_end = run_ok & insn_done & ~lat_q;
  wire hw_go = ~interrupt_mask_bit & (|(irq_req & irq_en));
  wire take_swi = at_end & (break_req | swi_insn);
  wire take_hw = at_end & ~break_req & ~swi_insn & hw_go;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lat_q <= 1'b0;
      vec_q <= '0;
      pcm1_q <= 1'b0;
      entry_q <= 1'b0;
      restore_q <= 1'b0;
    end else begin
      entry_q <= take_swi | take_hw;
      restore_q <= rti_insn & run_ok;
      if (take_swi) begin
        lat_q <= 1'b1;
        vec_q <= `VEC_SWI;
        pcm1_q <= 1'b0;
      end else if (take_hw) begin
        lat_q <= 1'b1;
        vec_q <= pick_source(irq_req & irq_en);
        pcm1_q <= 1'b1;
      end else if (vector_ack | ~run_ok) begin
        lat_q <= 1'b0;
      end
    end
  end

  // apb slave: data staged in the setup cycle, answer in the first access cycle
  wire setup = psel & ~penable;
  wire access = psel & penable & ready_q;
  wire hit_high = (paddr == `OFS_PEND_HIGH);
  wire hit_mid = (paddr == `OFS_PEND_MID);
  wire hit_low = (paddr == `OFS_PEND_LOW);
  wire hit_cause = (paddr == `OFS_CAUSE);
  wire hit_ctrl = (paddr == `OFS_CTRL);
  wire mapped = hit_high | hit_mid | hit_low | hit_cause | hit_ctrl;
  wire [31:0] rd_high = {24'h000000, irq_req[5:0], 2'b00};
  wire [31:0] rd_mid = {24'h000000, irq_req[13:6]};
  wire [31:0] rd_low = {30'h0, irq_req[15:14]};
  wire [31:0] rd_mux = hit_high ? rd_high : hit_mid ? rd_mid : hit_low ? rd_low :
                       hit_cause ? {27'h0, cause_q} :
                       hit_ctrl ? {30'h0, ctrl_q} : 32'h00000000;
  // read of the cause register clears it, a same-cycle event still lands
  wire cause_rd_clr = access & ~pwrite & hit_cause;
  wire [4:0] cause_set = {ext_low & (state_q != ST_EXT), ev_monitor, ev_undervolt,
                          ev_badfetch, ev_illegal};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_q <= '0;
      ready_q <= 1'b0;
      err_q <= 1'b0;
      ctrl_q <= `CTRL_RESET;
      cause_q <= '0;
    end else begin
      ready_q <= setup;
      if (setup) begin
        rdata_q <= pwrite ? 32'h00000000 : rd_mux;
        err_q <= ~mapped;
      end
      // pending flag registers take no write at all
      if (access & pwrite & hit_ctrl) begin
        ctrl_q <= pwdata[1:0];
      end
      cause_q <= (cause_rd_clr ? 5'h00 : cause_q) | cause_set;
    end
  end

  assign prdata = rdata_q;
  assign pready = ready_q;
  assign pslverr = err_q;
  assign rst_pin_o = 1'b0;
  assign rst_pin_oe = oe_q;
  assign internal_reset_line = internal_reset_line_q;
  assign bus_clk_en = busen_q;
  assign watchdog_tick = wd_q;
  assign int_entry = entry_q;
  assign vector_sel = vec_q;
  assign stack_pc_minus_one = pcm1_q;
  assign push_index_high = 1'b0;
  assign restore_regs = restore_q;

  // helper: osc ticks spent with the pin driven in the current run
  logic [12:0] low_ticks_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      low_ticks_q <= '0;
    end else if (!oe_q) begin
      low_ticks_q <= '0;
    end else if (osc_tick) begin
      low_ticks_q <= low_ticks_q + 13'h0001;
    end
  end

  chk_illegal_resets: assert property (@(posedge pclk) disable iff (!presetn)
    undefined_insn |=> rst_pin_oe && internal_reset_line && cause_q[`CAUSE_ILLEGAL_BIT])
    else $error("illegal instruction did not reset");
  chk_stop_disabled: assert property (@(posedge pclk) disable iff (!presetn)
    (stop_insn && !stop_en) |=> state_q == ST_PIN && cause_q[`CAUSE_ILLEGAL_BIT])
    else $error("disabled stop did not reset");
  chk_pin_drive: assert property (@(posedge pclk) disable iff (!presetn)
    (state_q == ST_PIN) |-> rst_pin_oe && !rst_pin_o)
    else $error("pin not driven low during internal reset");
  chk_badfetch_reset: assert property (@(posedge pclk) disable iff (!presetn)
    (unmapped_access && opcode_fetch) |=> cause_q[`CAUSE_BADFETCH_BIT] && rst_pin_oe)
    else $error("bad fetch did not reset");
  chk_data_no_reset: assert property (@(posedge pclk) disable iff (!presetn)
    (state_q == ST_RUN && unmapped_access && !opcode_fetch && !undefined_insn && !stop_insn
     && !undervoltage && !monitor_entry_reset && rst_pin_i && !cause_rd_clr)
    |=> state_q != ST_PIN && $stable(cause_q[`CAUSE_BADFETCH_BIT]))
    else $error("data access caused a reset");
  chk_pin_short_len: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(rst_pin_oe) && !long_q |-> $past(low_ticks_q) == 13'(`PIN_LOW_OSC_CYCLES - 1))
    else $error("short reset pin pulse has wrong length");
  chk_pin_long_len: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(rst_pin_oe) && long_q |-> $past(low_ticks_q) == LONG_LAST)
    else $error("long reset pin pulse has wrong length");
  chk_stop_clears: assert property (@(posedge pclk) disable iff (!presetn)
    stop_go |=> cnt_q == '0 && state_q == ST_STOP)
    else $error("stop did not clear counter");
  chk_wd_overflow: assert property (@(posedge pclk) disable iff (!presetn)
    cnt_wrap |=> watchdog_tick && cnt_q == '0)
    else $error("counter overflow did not tick watchdog");
  chk_ext_keeps_count: assert property (@(posedge pclk) disable iff (!presetn)
    (state_q == ST_EXT && !ev_internal && !osc_tick) |=> $stable(cnt_q))
    else $error("external reset changed counter");
  chk_recover_bus: assert property (@(posedge pclk) disable iff (!presetn)
    (state_q == ST_RECOVER && !ev_internal) |=> !bus_clk_en || state_q != ST_RECOVER)
    else $error("bus clock ran during recovery");
  chk_swi_vector: assert property (@(posedge pclk) disable iff (!presetn)
    take_swi |=> int_entry && vector_sel == `VEC_SWI && !stack_pc_minus_one)
    else $error("trap entry wrong");
  chk_mask_blocks: assert property (@(posedge pclk) disable iff (!presetn)
    (interrupt_mask_bit && !swi_insn && !break_req) |=> !int_entry)
    else $error("masked interrupt taken");
  chk_latch_holds: assert property (@(posedge pclk) disable iff (!presetn)
    (lat_q && !vector_ack && run_ok) |=> $stable(vector_sel))
    else $error("latched vector displaced");
  chk_flags_read: assert property (@(posedge pclk) disable iff (!presetn)
    (setup && !pwrite && hit_low) |=> prdata[31:2] == '0 && prdata[1:0] == $past(irq_req[15:14]))
    else $error("low flag register read wrong");

  cov_hw_interrupt: cover property (@(posedge pclk) disable iff (!presetn) take_hw ##1 int_entry);
  cov_long_reset: cover property (@(posedge pclk) disable iff (!presetn)
    $fell(rst_pin_oe) && long_q);
  cov_stop_wake: cover property (@(posedge pclk) disable iff (!presetn)
    state_q == ST_RECOVER ##1 state_q == ST_RUN);
  cov_break: cover property (@(posedge pclk) disable iff (!presetn) take_swi && break_req);
endmodule : reset_and_exception_control
`default_nettype wire

/* test/cpu_core_model.sv */
// behavioural cpu core facing the exception unit: mask bit and vector fetch
`timescale 1ns/1ps
`default_nettype none
module cpu_core_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic int_entry,
  input wire logic restore_regs,
  input wire logic clear_mask,
  input wire logic [3:0] ack_delay,
  output logic vector_ack,
  output logic interrupt_mask_bit
);
  logic [3:0] wait_q;
  logic busy_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wait_q <= 4'h0;
      busy_q <= 1'b0;
      vector_ack <= 1'b0;
      interrupt_mask_bit <= 1'b1;
    end else begin
      vector_ack <= busy_q && (wait_q == 4'h0);
      if (restore_regs || clear_mask) begin
        interrupt_mask_bit <= 1'b0;
      end
      // entry wins over a same-cycle restore, as stacking sets the mask last
      if (int_entry) begin
        busy_q <= 1'b1;
        wait_q <= ack_delay;
        interrupt_mask_bit <= 1'b1;
      end else if (busy_q && wait_q == 4'h0) begin
        busy_q <= 1'b0;
      end else if (busy_q) begin
        wait_q <= wait_q - 4'h1;
      end
    end
  end
endmodule : cpu_core_model
`default_nettype wire

/* test/tb_top.sv */
// self-checking bench for the reset and exception unit
`timescale 1ns/1ps
`default_nettype none
`include "reset_exc_consts.svh"
module tb_top;
  import reset_exc_pkg::*;
  localparam int LONG = 64;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, err, rst_pin_o, rst_pin_oe, internal_reset_line;
  logic bus_clk_en, watchdog_tick, vector_ack, interrupt_mask_bit, int_entry;
  logic stack_pc_minus_one, push_index_high, restore_regs;
  logic undervoltage = 1'b0, insn_done = 1'b0, swi_insn = 1'b0, rti_insn = 1'b0;
  logic break_req = 1'b0, clear_mask = 1'b0;
  logic [3:0] ack_delay = 4'h3;
  logic [1:0] osc_div = 2'h0;
  logic [4:0] ev = 5'h00;
  logic [4:0] ev_tab [6] = '{5'h01, 5'h02, 5'h0C, 5'h10, 5'h08, 5'h00};
  logic [31:0] cause_tab [6] = '{32'h1, 32'h1, 32'h2, 32'h8, 32'h0, 32'h4};
  source_vec_t irq_req = 16'h0000, irq_en = 16'hFFFF;
  vector_code_t vector_sel;
  int fail_count = 0, tests_run = 0, cyc = 0, n;
  wire logic osc_clk = osc_div[1];
  wire logic undefined_insn = ev[0];
  wire logic stop_insn = ev[1];
  wire logic opcode_fetch = ev[2];
  wire logic unmapped_access = ev[3];
  wire logic monitor_entry_reset = ev[4];
  // pull-up on the reset pin when nobody drives it
  wire logic rst_pin_wire = rst_pin_oe ? rst_pin_o : 1'b1;

  reset_and_exception_control #(.LONG_COUNT(LONG)) reset_and_exception_control_inst (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .osc_clk, .undefined_insn, .stop_insn, .opcode_fetch, .unmapped_access,
    .undervoltage, .monitor_entry_reset, .rst_pin_i(rst_pin_wire), .rst_pin_o,
    .rst_pin_oe, .internal_reset_line, .bus_clk_en, .watchdog_tick, .insn_done,
    .interrupt_mask_bit, .irq_req, .irq_en, .swi_insn, .rti_insn, .break_req,
    .vector_ack, .int_entry, .vector_sel, .stack_pc_minus_one, .push_index_high,
    .restore_regs);
  cpu_core_model cpu_core_model_inst (.pclk, .presetn, .int_entry, .restore_regs,
    .clear_mask, .ack_delay, .vector_ack, .interrupt_mask_bit);

  initial begin
    forever #5 pclk = ~pclk;
  end
  // oscillator at a quarter of pclk, each level held two cycles
  always @(posedge pclk) begin
    osc_div <= osc_div + 2'h1;
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      fail_count++;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    if (fail_count == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : tally_and_finish
  task automatic chk_eq(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_eq
  // osc ticks are seen through pclk sampling, so allow a couple of ticks
  task automatic chk_near(input int got, input int exp);
    chk_eq((got - exp <= 8 && exp - got <= 8) ? exp : got, exp);
  endtask : chk_near
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    // pready is looked at between edges, where it has settled
    do begin
      @(negedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // one-cycle strobe: 0 mask clear, 1 instruction end, 2 return, 3 stop
  task automatic pulse(input int which);
    @(posedge pclk);
    case (which)
      0: clear_mask <= 1'b1;
      1: insn_done <= 1'b1;
      2: rti_insn <= 1'b1;
      default: ev <= 5'h02;
    endcase
    @(posedge pclk);
    clear_mask <= 1'b0;
    insn_done <= 1'b0;
    rti_insn <= 1'b0;
    ev <= 5'h00;
  endtask : pulse
  task automatic reset_seq(input int pin_ticks, input int hold_ticks);
    int a;
    int b;
    a = 0;
    b = 0;
    n = 0;
    while (rst_pin_oe !== 1'b1 && n < 20) begin
      @(posedge pclk);
      n++;
    end
    while (rst_pin_oe === 1'b1 && a < 40000) begin
      @(posedge pclk);
      a++;
    end
    chk_eq(internal_reset_line, 1'b1);
    while (bus_clk_en !== 1'b1 && b < 40000) begin
      @(posedge pclk);
      b++;
    end
    chk_near(a, pin_ticks * 4);
    chk_near(b, hold_ticks * 4);
  endtask : reset_seq
  task automatic wait_int(input logic [4:0] v, input logic pcm);
    n = 0;
    while (int_entry !== 1'b1 && n < 8) begin
      @(negedge pclk);
      n++;
    end
    chk_eq({int_entry, stack_pc_minus_one, push_index_high, vector_sel},
           {1'b1, pcm, 1'b0, v});
  endtask : wait_int

  initial begin
    repeat (8) @(posedge pclk);
    chk_eq({internal_reset_line, bus_clk_en, rst_pin_oe}, 3'b101);
    presetn <= 1'b1;
    reset_seq(LONG, 64);
    apb(1'b0, `OFS_CTRL, 32'h0);
    chk_eq(rd, 32'h0);
    apb(1'b0, `OFS_CAUSE, 32'h0);
    for (int k = 0; k < 6; k++) begin
      @(posedge pclk);
      ev <= ev_tab[k];
      undervoltage <= (k == 5);
      @(posedge pclk);
      ev <= 5'h00;
      undervoltage <= 1'b0;
      if (k != 4) begin
        reset_seq(k == 5 ? LONG : 32, k == 5 ? 64 : 32);
      end else begin
        repeat (20) @(posedge pclk);
        chk_eq(rst_pin_oe, 1'b0);
      end
      apb(1'b0, `OFS_CAUSE, 32'h0);
      chk_eq(rd & 32'hF, cause_tab[k]);
    end
    irq_req <= 16'hC024;
    apb(1'b0, `OFS_PEND_HIGH, 32'h0);
    chk_eq(rd, 32'h90);
    apb(1'b1, `OFS_PEND_HIGH, 32'hFF);
    apb(1'b0, `OFS_PEND_HIGH, 32'h0);
    chk_eq(rd, 32'h90);
    apb(1'b0, `OFS_PEND_LOW, 32'h0);
    chk_eq(rd, 32'h3);
    apb(1'b0, 12'h020, 32'h0);
    chk_eq({rd[30:0], err}, 32'h1);
    pulse(0);
    pulse(1);
    wait_int(5'h04, 1'b1);
    irq_req <= 16'hC020;
    ack_delay <= 4'hA;
    repeat (14) @(posedge pclk);
    pulse(2);
    @(negedge pclk);
    chk_eq(restore_regs, 1'b1);
    pulse(1);
    wait_int(5'h07, 1'b1);
    repeat (14) @(posedge pclk);
    pulse(1);
    n = 0;
    repeat (6) begin
      @(negedge pclk);
      if (int_entry !== 1'b0) n++;
    end
    chk_eq(n, 0);
    @(posedge pclk);
    swi_insn <= 1'b1;
    pulse(1);
    swi_insn <= 1'b0;
    wait_int(`VEC_SWI, 1'b0);
    repeat (14) @(posedge pclk);
    break_req <= 1'b1;
    pulse(1);
    wait_int(`VEC_SWI, 1'b0);
    break_req <= 1'b0;
    irq_req <= 16'h0000;
    apb(1'b1, `OFS_CTRL, 32'h3);
    pulse(3);
    repeat (8) @(posedge pclk);
    chk_eq({rst_pin_oe, bus_clk_en}, 2'b00);
    irq_req <= 16'h0001;
    n = 0;
    while (bus_clk_en !== 1'b1 && n < 2000) begin
      @(posedge pclk);
      n++;
    end
    chk_near(n, 32 * 4);
    irq_req <= 16'h0000;
    n = 0;
    while (watchdog_tick !== 1'b1 && n < 40000) begin
      @(negedge pclk);
      n++;
    end
    n = 0;
    do begin
      @(negedge pclk);
      n++;
    end while (watchdog_tick !== 1'b1 && n < 40000);
    chk_near(n, 8192 * 4);
    tally_and_finish();
  end
endmodule : tb_top
`default_nettype wire
